// file: rtl/adcif_host.sv
// Purpose: Host controller end, driving the shared pins from APB registers
// Assumes: pclk 10 MHz; straps written before a transfer starts
// Notes:   Makes the serial clock by dividing pclk
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "adcif_consts.svh"
module adcif_host #(
    parameter int DIV_HALF = 6                       // pclk cycles per sclk half period
)(
    input  wire logic        pclk,    // System clock
    input  wire logic        presetn, // Async reset, active low
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB enable
    input  wire logic        pwrite,  // APB write
    input  wire logic [7:0]  paddr,   // APB byte address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic [31:0]      prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error, unmapped address
    adcif_link.host          lnk      // Shared pins
);
    import adcif_pkg::*;

    if (DIV_HALF < `ADCIF_HOST_MIN_HALF || `ADCIF_PCLK_HZ / (2 * DIV_HALF) > `ADCIF_SCLK_MAX_HZ) begin : g_chk
        $error("DIV_HALF too small");
    end

    logic [31:0]        ctrl_r;
    adcif_cw_t          cword_r;
    adcif_hst_t         st_r;
    adcif_word_t        rx_r [`ADCIF_RX_WORDS];
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [7:0]         div_r;
    logic [6:0]         bit_r;
    logic [4:0]         ph_r;
    logic               sclk_r;
    logic               sin_r;
    logic               rd_n_r;
    logic               frm_n_r;
    logic [15:0]        d1_r;
    logic [15:0]        d2_r;
    logic [15:0]        d3_r;
    logic [15:0]        din_r;
    adcif_word_t        out_nxt;
    adcif_word_t        oe_nxt;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    wire       is_byte  = ctrl_r[`ADCIF_CTRL_BYTE];
    wire       hbf      = ctrl_r[`ADCIF_CTRL_HBF];
    wire [2:0] sel      = ctrl_r[`ADCIF_CTRL_SEL_HI:`ADCIF_CTRL_SEL_LO];
    wire [6:0] flen     = ctrl_r[`ADCIF_CTRL_LEN_HI:`ADCIF_CTRL_LEN_LO];
    wire       wr_en    = psel && penable && pready_r && pwrite;
    wire       in_data  = paddr >= `ADCIF_OFF_DATA0 && paddr < `ADCIF_OFF_DATAEND;
    wire [4:0] rd_idx   = 5'((paddr - `ADCIF_OFF_DATA0) >> 2);
    wire       mapped   = paddr == `ADCIF_OFF_CTRL || paddr == `ADCIF_OFF_CMD || paddr == `ADCIF_OFF_CWORD
                       || paddr == `ADCIF_OFF_STAT || in_data;
    wire [31:0] rd_val  = paddr == `ADCIF_OFF_CTRL  ? ctrl_r
                        : paddr == `ADCIF_OFF_CWORD ? cword_r
                        : paddr == `ADCIF_OFF_STAT  ? {31'h0, st_r != H_IDLE}
                        : in_data ? {16'h0, rx_r[rd_idx]} : 32'h0;
    wire       div_end  = div_r == 8'(DIV_HALF - 1);
    wire       sclk_fall = st_r == H_SER && div_end && sclk_r;
    wire [3:0] beats    = is_byte ? 4'(`ADCIF_NBYTES) : 4'(`ADCIF_NWORDS);
    wire       hi_lane  = (bit_r[0] == 1'b0) == hbf;

    // Pin image; sels low mean this end holds the matching output at ground
    always_comb begin
        out_nxt = '0;
        oe_nxt  = `ADCIF_MASK_NONE;
        if (ctrl_r[`ADCIF_CTRL_ISEL]) begin
            oe_nxt                     = {5'h1F, ~sel, 8'hFF};
            out_nxt[`ADCIF_PIN_REFEN]  = !ctrl_r[`ADCIF_CTRL_SW] && ctrl_r[`ADCIF_CTRL_REFEN];
            out_nxt[`ADCIF_PIN_SIN]    = ctrl_r[`ADCIF_CTRL_SW] && sin_r;
            out_nxt[`ADCIF_PIN_HBF]    = ctrl_r[`ADCIF_CTRL_CHAIN];
            out_nxt[`ADCIF_PIN_SCLK]   = sclk_r;
            // Chain test data follows the control word; ground when unused
            out_nxt[5:3]               = {3{ctrl_r[`ADCIF_CTRL_CHAIN] && sin_r}};
            out_nxt[2:0]               = sel;
        end else if (is_byte) begin
            oe_nxt                     = `ADCIF_MASK_LOBYTE;
            out_nxt[`ADCIF_PIN_HBF]    = hbf;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= `ADCIF_CTRL_RST;
            cword_r   <= `ADCIF_CW_RST;
            st_r      <= H_IDLE;
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            div_r     <= '0;
            bit_r     <= '0;
            ph_r      <= '0;
            sclk_r    <= 1'b0;
            sin_r     <= 1'b0;
            rd_n_r    <= 1'b1;
            frm_n_r   <= 1'b1;
            d1_r      <= '0;
            d2_r      <= '0;
            d3_r      <= '0;
            din_r     <= '0;
            for (int i = 0; i < `ADCIF_RX_WORDS; i++) begin
                rx_r[i] <= '0;
            end
            lnk.interface_select      <= 1'b0;
            lnk.control_source_select <= 1'b0;
            lnk.word_byte             <= 1'b0;
            lnk.read_n                <= 1'b1;
            lnk.frame_n               <= 1'b1;
            lnk.host_out              <= '0;
            lnk.host_oe               <= '0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_r <= rd_val;
            end
            if (wr_en && paddr == `ADCIF_OFF_CTRL) begin
                ctrl_r <= pwdata;
            end
            if (wr_en && paddr == `ADCIF_OFF_CWORD) begin
                cword_r <= pwdata;
            end
            d1_r  <= lnk.db;
            d2_r  <= d1_r;
            d3_r  <= d2_r;
            din_r <= (d2_r & d3_r) | (din_r & (d2_r | d3_r));
            case (st_r)
                H_IDLE: begin
                    div_r <= '0;
                    bit_r <= '0;
                    ph_r  <= '0;
                    if (wr_en && paddr == `ADCIF_OFF_CMD && pwdata[`ADCIF_CMD_SER]) begin
                        st_r    <= H_SER;
                        frm_n_r <= 1'b0;
                        sin_r   <= cword_r[`ADCIF_CW_BITS - 1];
                    end else if (wr_en && paddr == `ADCIF_OFF_CMD && pwdata[`ADCIF_CMD_PAR]) begin
                        st_r   <= H_PAR;
                        rd_n_r <= 1'b0;
                    end
                end
                H_SER: begin
                    div_r <= div_end ? 8'h00 : 8'(div_r + 8'h01);
                    if (div_end) begin
                        sclk_r <= !sclk_r;
                    end
                    if (sclk_fall) begin
                        rx_r[5'(bit_r >> 4)]      [4'hF - bit_r[3:0]] <= din_r[`ADCIF_PIN_OUT1];
                        rx_r[5'(6 + (bit_r >> 4))][4'hF - bit_r[3:0]] <= din_r[`ADCIF_PIN_OUT2];
                        rx_r[5'(12 + (bit_r >> 4))][4'hF - bit_r[3:0]] <= din_r[`ADCIF_PIN_OUT3];
                        // Control word repeats, so chain pins carry data all frame
                        sin_r <= cword_r[5'(30 - bit_r)];
                        bit_r <= 7'(bit_r + 7'h01);
                        if (bit_r == 7'(flen - 7'h01)) begin
                            st_r <= H_END;
                        end
                    end
                end
                H_END: begin
                    frm_n_r <= 1'b1;
                    sin_r   <= 1'b0;
                    st_r    <= H_IDLE;
                end
                H_PAR: begin
                    ph_r <= 5'(ph_r + 5'h01);
                    if (ph_r == `ADCIF_PAR_PHASE - 5'h01) begin
                        rd_n_r <= 1'b1;
                        if (is_byte && hi_lane) begin
                            rx_r[5'(bit_r >> 1)][15:8] <= din_r[15:8];
                        end else if (is_byte) begin
                            rx_r[5'(bit_r >> 1)][7:0] <= din_r[15:8];
                        end else begin
                            rx_r[5'(bit_r)] <= din_r;
                        end
                    end else if (ph_r == 5'(2 * `ADCIF_PAR_PHASE - 1)) begin
                        ph_r  <= '0;
                        bit_r <= 7'(bit_r + 7'h01);
                        if (bit_r == 7'(beats - 4'h1)) begin
                            st_r <= H_IDLE;
                        end else begin
                            rd_n_r <= 1'b0;
                        end
                    end
                end
                default: st_r <= H_IDLE;
            endcase
            lnk.interface_select      <= ctrl_r[`ADCIF_CTRL_ISEL];
            lnk.control_source_select <= ctrl_r[`ADCIF_CTRL_SW];
            lnk.word_byte             <= is_byte;
            lnk.read_n                <= rd_n_r;
            lnk.frame_n               <= frm_n_r;
            lnk.host_out              <= out_nxt;
            lnk.host_oe               <= oe_nxt;
        end
    end
endmodule

// file: rtl/adcif_consts.svh
// Purpose: Shared constants of the converter host-interface pin mux
// Assumes: Included by bare name
// Notes:   Byte offsets are for the host controller APB slave
`ifndef ADCIF_CONSTS_SVH
`define ADCIF_CONSTS_SVH

// Shared pin positions on the 16-bit data bus
`define ADCIF_PIN_REFEN     14
`define ADCIF_PIN_SIN       13
`define ADCIF_PIN_OUT3      10
`define ADCIF_PIN_OUT2      9
`define ADCIF_PIN_OUT1      8
`define ADCIF_PIN_HBF       7
`define ADCIF_PIN_SCLK      6
`define ADCIF_PIN_CHAIN1    5
`define ADCIF_PIN_CHAIN2    4
`define ADCIF_PIN_CHAIN3    3
`define ADCIF_MASK_WORD     16'hFFFF
`define ADCIF_MASK_HIBYTE   16'hFF00
`define ADCIF_MASK_LOBYTE   16'h00FF
`define ADCIF_MASK_NONE     16'h0000

// Control word and serial frame
`define ADCIF_CW_BITS       32
`define ADCIF_CW_REF_BUFFER_CTRL_BIT     24
`define ADCIF_CW_RST        32'h0000_0000
`define ADCIF_FRAME_MAX     96
`define ADCIF_LEN_ALL       7'h60
`define ADCIF_LEN_THREE     7'h30
`define ADCIF_LEN_TWO       7'h20
`define ADCIF_CNT_SAT       7'h7F
`define ADCIF_NWORDS        6
`define ADCIF_NBYTES        12
`define ADCIF_DSYNC_RST     11'h0E0

// Timing
`define ADCIF_PCLK_HZ       10000000
`define ADCIF_SCLK_MAX_HZ   36000000
`define ADCIF_HOST_MIN_HALF 6
`define ADCIF_PAR_PHASE     5'h0C

// Host APB map
`define ADCIF_OFF_CTRL      8'h00
`define ADCIF_OFF_CMD       8'h04
`define ADCIF_OFF_CWORD     8'h08
`define ADCIF_OFF_STAT      8'h0C
`define ADCIF_OFF_DATA0     8'h10
`define ADCIF_OFF_DATAEND   8'h58
`define ADCIF_CTRL_RST      32'h0060_0020
`define ADCIF_RX_WORDS      18
`define ADCIF_CMD_SER       0
`define ADCIF_CMD_PAR       1
`define ADCIF_CTRL_ISEL     0
`define ADCIF_CTRL_SW       1
`define ADCIF_CTRL_BYTE     2
`define ADCIF_CTRL_HBF      3
`define ADCIF_CTRL_CHAIN    4
`define ADCIF_CTRL_SEL_LO   5
`define ADCIF_CTRL_SEL_HI   7
`define ADCIF_CTRL_REFEN    8
`define ADCIF_CTRL_LEN_LO   16
`define ADCIF_CTRL_LEN_HI   22

`endif

// file: rtl/adcif_pkg.sv
// Purpose: Types of the converter host-interface pin mux
// Assumes: Nothing
// Notes:   Constants live in adcif_consts.svh
package adcif_pkg;
    typedef logic [15:0] adcif_word_t;
    typedef logic [31:0] adcif_cw_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SER  = 2'b01,
        H_END  = 2'b11,
        H_PAR  = 2'b10
    } adcif_hst_t;
    typedef struct packed {
        logic       isel;
        logic       sw;
        logic       byte_m;
        logic       rd_n;
        logic       frm_n;
        logic       refen_n;
        logic       hbf_chain;
        logic [2:0] sel;
        logic       cw_tgl;
    } adcif_dsync_t;
endpackage

// file: rtl/adcif_link.sv
// Purpose: Shared pins between converter end and host controller end
// Assumes: Undriven pin bits read low, as if tied to ground
// Notes:   Resolves the three-signal pin ports into wire levels
`timescale 1ns/10ps
`include "adcif_consts.svh"
interface adcif_link;
    logic        interface_select;      // 0 parallel, 1 serial
    logic        control_source_select; // 0 hardware, 1 software
    logic        word_byte;             // 0 word, 1 byte
    logic        read_n;                // Parallel read strobe
    logic        frame_n;               // Serial frame
    logic [15:0] host_out;
    logic [15:0] host_oe;
    logic [15:0] dev_par_out;
    logic [15:0] dev_oe;
    logic [2:0]  dev_ser_out;
    logic [15:0] dev_mix;
    logic [15:0] db;
    logic        sclk;

    assign dev_mix = interface_select ? {dev_par_out[15:11], dev_ser_out, dev_par_out[7:0]} : dev_par_out;
    assign db      = (dev_oe & dev_mix) | (~dev_oe & host_oe & host_out);
    assign sclk    = db[`ADCIF_PIN_SCLK];

    modport dev  (input interface_select, control_source_select, word_byte, read_n, frame_n, db, sclk,
                  output dev_par_out, dev_oe, dev_ser_out);
    modport host (output interface_select, control_source_select, word_byte, read_n, frame_n,
                  host_out, host_oe, input db);
endinterface

// file: rtl/adcif_dev.sv
// Purpose: Converter end of the host-interface pin mux
// Assumes: Straps static while a frame or a read runs
// Notes:   Serial logic on the link clock, the rest on pclk
`timescale 1ns/10ps
`include "adcif_consts.svh"
module adcif_dev #(
    parameter int RES = 16                          // Result width: 16, 14 or 12
)(
    input  wire logic                     pclk,             // System clock
    input  wire logic                     presetn,          // Async reset, active low
    input  wire logic                     load,             // Result set strobe
    input  wire logic [5:0][RES-1:0]      result,           // A0 A1 B0 B1 C0 C1
    output logic                          load_ok_r,        // Result set taken
    output logic                          ref_buffers_on_r, // Reference buffers on
    output adcif_pkg::adcif_cw_t          control_word_r,   // Last control word
    output logic                          cw_update_r,      // New control word pulse
    output logic                          serial_mode_r,    // Serial link selected
    adcif_link.dev                        lnk               // Shared pins
);
    import adcif_pkg::*;

    if (!(RES == 16 || RES == 14 || RES == 12)) begin : g_chk
        $error("RES must be 16, 14 or 12");
    end

    // Pin synchronisers, three stages, change when stages 2 and 3 agree
    adcif_dsync_t pin_raw;
    adcif_dsync_t s1_r;
    adcif_dsync_t s2_r;
    adcif_dsync_t s3_r;
    adcif_dsync_t pin_r;
    logic         cw_tgl_r;
    adcif_cw_t    cw_hold_r;

    assign pin_raw = '{isel: lnk.interface_select, sw: lnk.control_source_select, byte_m: lnk.word_byte,
                       rd_n: lnk.read_n, frm_n: lnk.frame_n, refen_n: lnk.db[`ADCIF_PIN_REFEN],
                       hbf_chain: lnk.db[`ADCIF_PIN_HBF], sel: lnk.db[2:0], cw_tgl: cw_tgl_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r  <= `ADCIF_DSYNC_RST;
            s2_r  <= `ADCIF_DSYNC_RST;
            s3_r  <= `ADCIF_DSYNC_RST;
            pin_r <= `ADCIF_DSYNC_RST;
        end else begin
            s1_r  <= pin_raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    // Decoded modes
    wire       ser_mode  = pin_r.isel;
    wire       sw_mode   = pin_r.sw;
    wire       chain_en  = ser_mode & pin_r.hbf_chain;
    wire       rd_act    = !ser_mode && !pin_r.rd_n;
    wire       frame_act = ser_mode && !pin_r.frm_n;
    wire [3:0] last_beat = pin_r.byte_m ? 4'(`ADCIF_NBYTES - 1) : 4'(`ADCIF_NWORDS - 1);

    // Parallel side: snapshot, beat index, pin drive
    adcif_word_t snap_r [6];
    logic [3:0]  beat_r;
    logic        rd_prev_r;
    logic        cw_seen_r;
    wire         load_take = load && !frame_act && !rd_act;
    wire         rd_done   = rd_prev_r && !rd_act;
    adcif_word_t beat_word;
    logic [7:0]  beat_byte;
    adcif_word_t par_nxt;
    adcif_word_t oe_nxt;
    logic        ref_nxt;

    assign beat_word = snap_r[pin_r.byte_m ? 3'(beat_r >> 1) : 3'(beat_r)];
    // First byte of a pair is the high one when high_byte_first is set
    assign beat_byte = ((beat_r[0] == 1'b0) == pin_r.hbf_chain) ? beat_word[15:8] : beat_word[7:0];
    assign par_nxt   = pin_r.byte_m ? {beat_byte, 8'h00} : beat_word;
    assign oe_nxt    = ser_mode ? {5'h00, pin_r.sel, 8'h00}
                     : !rd_act ? `ADCIF_MASK_NONE
                     : pin_r.byte_m ? `ADCIF_MASK_HIBYTE : `ADCIF_MASK_WORD;
    assign ref_nxt   = (ser_mode && !sw_mode) ? !pin_r.refen_n
                     : control_word_r[`ADCIF_CW_REF_BUFFER_CTRL_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `ADCIF_NWORDS; i++) begin
                snap_r[i] <= '0;
            end
            beat_r           <= '0;
            rd_prev_r        <= 1'b0;
            cw_seen_r        <= 1'b0;
            load_ok_r        <= 1'b0;
            ref_buffers_on_r <= 1'b0;
            control_word_r   <= `ADCIF_CW_RST;
            cw_update_r      <= 1'b0;
            serial_mode_r    <= 1'b0;
            lnk.dev_par_out  <= '0;
            lnk.dev_oe       <= '0;
        end else begin
            if (load_take) begin
                for (int i = 0; i < `ADCIF_NWORDS; i++) begin
                    snap_r[i] <= adcif_word_t'(result[i]);
                end
            end
            if (load_take || ser_mode) begin
                beat_r <= '0;
            end else if (rd_done) begin
                beat_r <= (beat_r == last_beat) ? 4'h0 : 4'(beat_r + 4'h1);
            end
            rd_prev_r        <= rd_act;
            load_ok_r        <= load_take;
            cw_seen_r        <= pin_r.cw_tgl;
            cw_update_r      <= cw_seen_r != pin_r.cw_tgl;
            if (cw_seen_r != pin_r.cw_tgl) begin
                control_word_r <= cw_hold_r;
            end
            ref_buffers_on_r <= ref_nxt;
            serial_mode_r    <= ser_mode;
            lnk.dev_par_out  <= par_nxt;
            lnk.dev_oe       <= oe_nxt;
        end
    end

    // Serial streams, built from the snapshot that is frozen during a frame
    logic [`ADCIF_FRAME_MAX-1:0] vec1;
    logic [`ADCIF_FRAME_MAX-1:0] vec2;
    logic [`ADCIF_FRAME_MAX-1:0] vec3;
    logic [6:0]                  len1;
    logic [6:0]                  len2;
    logic [6:0]                  cnt_r;
    logic [6:0]                  idx;
    logic [2:0]                  chain_in;
    logic [2:0]                  ser_nxt;
    adcif_cw_t                   cw_sh_r;

    always_comb begin
        if (pin_r.sel[2]) begin
            vec1 = {snap_r[0], snap_r[1], 64'h0};
            len1 = `ADCIF_LEN_TWO;
            vec2 = {snap_r[2], snap_r[3], 64'h0};
            len2 = `ADCIF_LEN_TWO;
        end else if (pin_r.sel[1]) begin
            vec1 = {snap_r[0], snap_r[1], snap_r[4], 48'h0};
            len1 = `ADCIF_LEN_THREE;
            vec2 = {snap_r[2], snap_r[3], snap_r[5], 48'h0};
            len2 = `ADCIF_LEN_THREE;
        end else begin
            vec1 = {snap_r[0], snap_r[1], snap_r[2], snap_r[3], snap_r[4], snap_r[5]};
            len1 = `ADCIF_LEN_ALL;
            vec2 = {snap_r[2], snap_r[3], snap_r[5], 48'h0};
            len2 = `ADCIF_LEN_THREE;
        end
    end

    assign vec3     = {snap_r[4], snap_r[5], 64'h0};
    assign idx      = 7'(`ADCIF_FRAME_MAX - 1) - cnt_r;
    // Chain pins only count while chaining is on
    assign chain_in = chain_en ? {lnk.db[`ADCIF_PIN_CHAIN3], lnk.db[`ADCIF_PIN_CHAIN2],
                                  lnk.db[`ADCIF_PIN_CHAIN1]} : 3'h0;
    // Own bits first, then upstream chain bits
    assign ser_nxt  = {(cnt_r < `ADCIF_LEN_TWO)  ? vec3[idx] : chain_in[2],
                       (cnt_r < len2)            ? vec2[idx] : chain_in[1],
                       (cnt_r < len1)            ? vec1[idx] : chain_in[0]};

    // Frame signal clears the bit counter, control word shifter and serial outputs; sclk may stop between frames
    always_ff @(posedge lnk.sclk or posedge lnk.frame_n) begin
        if (lnk.frame_n) begin
            cnt_r           <= '0;
            cw_sh_r         <= `ADCIF_CW_RST;
            lnk.dev_ser_out <= '0;
        end else begin
            cnt_r           <= (cnt_r == `ADCIF_CNT_SAT) ? cnt_r : 7'(cnt_r + 7'h1);
            lnk.dev_ser_out <= ser_nxt;
            if (sw_mode) begin
                cw_sh_r <= {cw_sh_r[30:0], lnk.db[`ADCIF_PIN_SIN]};
            end
        end
    end

    // Completed control word is held and flagged by a toggle
    always_ff @(posedge lnk.sclk or negedge presetn) begin
        if (!presetn) begin
            cw_tgl_r  <= 1'b0;
            cw_hold_r <= `ADCIF_CW_RST;
        end else if (!lnk.frame_n && sw_mode && cnt_r == 7'(`ADCIF_CW_BITS - 1)) begin
            cw_tgl_r  <= !cw_tgl_r;
            cw_hold_r <= {cw_sh_r[30:0], lnk.db[`ADCIF_PIN_SIN]};
        end
    end
endmodule

// file: bench/adcif_properties.sv
// Purpose: Link pin checks beside the shared pins
// Assumes: DIV_HALF of 6
// Notes:   Watches resolved pin levels only
`timescale 1ns/10ps
module adcif_properties (
    input wire logic        pclk,             // Clock
    input wire logic        presetn,          // Reset, active low
    input wire logic        interface_select, // 0 parallel, 1 serial
    input wire logic        read_n,           // Parallel read strobe
    input wire logic        frame_n,          // Serial frame
    input wire logic        sclk,             // Serial clock pin
    input wire logic [15:0] db                // Resolved pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ser = interface_select;
    property p_idle; ser && frame_n && $past(frame_n) |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("sclk off frame");
    property p_half; ser && $rose(sclk) |-> sclk[*6] ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("sclk half");
    property p_nfrm; !ser |-> frame_n; endproperty
    a_nfrm: assert property (p_nfrm) else $error("frame in par");
    property p_nrd; ser |-> read_n; endproperty
    a_nrd: assert property (p_nrd) else $error("read in ser");
    property p_out3; ser && !db[2] |-> !db[10]; endproperty
    a_out3: assert property (p_out3) else $error("out3");
    property p_out2; ser && !db[1] |-> !db[9]; endproperty
    a_out2: assert property (p_out2) else $error("out2");
    property p_chain; ser && !db[7] |-> db[5:3] == 3'h0; endproperty
    a_chain: assert property (p_chain) else $error("chain");
    property p_first; ser |-> db[0]; endproperty
    a_first: assert property (p_first) else $error("first");
endmodule

// file: bench/tb_top.sv
// Purpose: Both ends joined over the link, driven through APB
// Assumes: Default RES and DIV_HALF
// Notes:   Results come back through the host data registers
`timescale 1ns/10ps
module tb_top;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, load = '0;
    logic pready, pslverr, rbo, lok, cwu, smode;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, cw, wv;
    logic [31:0] ctl [7] = '{32'h0060_0023, 32'h0030_0063, 32'h0020_00E3, 32'h0060_0020, 32'h0060_0024,
                             32'h0060_002C, 32'h0030_00F3};
    logic [5:0][15:0] res = 96'hC1C6_C0C5_B1B4_B0B3_A1A2_A0A1;
    int errors = 0, num_checks = 0, n, t, m, nupd = 0;
    adcif_link lnk();
    adcif_dev i_adcif_dev (.pclk, .presetn, .load, .result(res), .load_ok_r(lok), .ref_buffers_on_r(rbo),
        .control_word_r(cw), .cw_update_r(cwu), .serial_mode_r(smode), .lnk);
    always @(posedge pclk) if (cwu === 1'b1) nupd <= nupd + 1;
    adcif_host i_adcif_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .lnk);
    adcif_properties i_adcif_properties (.pclk, .presetn, .interface_select(lnk.interface_select),
        .read_n(lnk.read_n), .frame_n(lnk.frame_n), .sclk(lnk.sclk), .db(lnk.db));
    always #50 pclk = ~pclk;
    task automatic stop_test;
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) errors++;
        if (g !== e) $display("Error %s exp %h got %h", s, e, g);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk);
        while (pready !== 1'b1 && ++n < 99);
        chk("rdy", 1, pready);
        if (pready !== 1'b1) stop_test;
        {psel, penable} <= 2'b00;
    endtask
    // Result index on output o, word j; 9 marks no own word
    function automatic int src(int k, int o, int j);
        if (k == 1) return (o == 2 || j > 2) ? 9 : (j < 2 ? 2 * o + j : 4 + o);
        return (k == 0 ? o == 0 : j < 2) ? 2 * o + j : 9;
    endfunction
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h60, 0);
        chk("err", 1, pslverr);
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        @(posedge pclk);
        chk("ldok", 1, lok);
        for (int k = 0; k < 7; k++) begin
            wv = {((k == 6) ? 8'h5A : {7'h00, k == 1}), 24'h0000A5};
            m = (k == 6) ? 2 : (k > 2) ? 0 : k;
            apb(1, 8'h00, ctl[k]);
            apb(1, 8'h08, wv);
            apb(1, 8'h04, ctl[k][0] ? 1 : 2);
            t = 0;
            do apb(0, 8'h0C, 0);
            while (prdata[0] !== 1'b0 && ++t < 2000);
            chk("busy", 0, prdata[0]);
            if (prdata[0] !== 1'b0) stop_test;
            repeat (6) @(posedge pclk);
            chk("cw", wv, cw);
            chk("ref", k == 1, rbo);
            chk("mode", ctl[k][0], smode);
            for (int i = 0; i < 18; i++) if (src(m, i / 6, i % 6) < 9) begin
                apb(0, 8'(16 + 4 * i), 0);
                chk("dat", res[src(m, i / 6, i % 6)], prdata);
            end else if (k == 6 && i % 6 == 2) begin
                apb(0, 8'(16 + 4 * i), 0);
                chk("chain", wv[31:16], prdata);
            end
        end
        for (int b = 0; b < 2; b++) begin
            apb(1, 8'h00, {23'h003000, b[0], 8'h21});
            repeat (8) @(posedge pclk);
            chk("ref hw", !b[0], rbo);
        end
        chk("upd", 4, nupd);
        stop_test;
    end
endmodule
